// >>> mcuid_defines.svh
// constants for the 14-bit instruction decoder: opcodes, addresses, register offsets
// assumes it is included once per compile unit by its bare name
`ifndef MCUID_DEFINES_SVH
`define MCUID_DEFINES_SVH
// ==========================================================================
// timing
`define MCUID_OSC_PER_CYCLE 4
// ==========================================================================
// byte-oriented nibbles, bits 11:8 with bits 13:12 = 00
`define MCUID_OP_MISC 4'h0
`define MCUID_OP_CLEAR 4'h1
`define MCUID_OP_SUB_ACC_FROM_FILE 4'h2
`define MCUID_OP_DEC_FILE 4'h3
`define MCUID_OP_OR_ACC_WITH_FILE 4'h4
`define MCUID_OP_AND_ACC_WITH_FILE 4'h5
`define MCUID_OP_XOR_ACC_WITH_FILE 4'h6
`define MCUID_OP_ADD_ACC_TO_FILE 4'h7
`define MCUID_OP_MOVE_FILE 4'h8
`define MCUID_OP_COMPLEMENT_FILE 4'h9
`define MCUID_OP_INC_FILE 4'ha
`define MCUID_OP_DEC_FILE_SKIP_ZERO 4'hb
`define MCUID_OP_ROTATE_RIGHT_CARRY 4'hc
`define MCUID_OP_ROTATE_LEFT_CARRY 4'hd
`define MCUID_OP_SWAP_NIBBLES 4'he
`define MCUID_OP_INC_FILE_SKIP_ZERO 4'hf
// misc words with bits 13:7 all zero
`define MCUID_WORD_RETURN 7'h08
`define MCUID_WORD_RETURN_INT 7'h09
`define MCUID_WORD_STANDBY 7'h63
`define MCUID_WORD_WATCHDOG_CLEAR_OP 7'h64
// ==========================================================================
// literal group nibbles, bits 13:12 = 11
`define MCUID_LIT_OR_LITERAL_ACC 4'h8
`define MCUID_LIT_AND_LITERAL_ACC 4'h9
`define MCUID_LIT_XOR_LITERAL_ACC 4'ha
// ==========================================================================
// file map within a bank
`define MCUID_ADDR_TIMER_ZERO_COUNT 7'h01
`define MCUID_ADDR_PORT_FIRST 7'h05
`define MCUID_ADDR_PORT_LAST 7'h09
`define MCUID_FILE_ADDR_MAX 7'h7f
// ==========================================================================
// software register port offsets
`define MCUID_REG_CTRL 8'h00
`define MCUID_REG_FLAGS 8'h04
`define MCUID_REG_ACC 8'h08
`define MCUID_REG_PC_LOW 8'h0c
`define MCUID_CTRL_RUN_BIT 0
`define MCUID_CTRL_RESET 8'h00
`define MCUID_STACK_DEPTH 8
`endif

// >>> mcuid_pkg.sv
// types shared by the instruction decoder
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package mcuid_pkg;
  // one-hot oscillator phase within an instruction cycle
  typedef enum logic [3:0] {
    PH_Q1 = 4'b0001,
    PH_Q2 = 4'b0010,
    PH_Q3 = 4'b0100,
    PH_Q4 = 4'b1000
  } mcuid_phase_t;
  typedef logic [13:0] mcuid_word_t;
  typedef logic [12:0] mcuid_pc_t;
endpackage
`default_nettype wire

// >>> mcuid_core.sv
// instruction decoder and executor of an 8-bit accumulator core with 14-bit words
// assumes program memory answers progAddr within the Q1 phase and the register
// file answers fileAddr by Q3; inputs are synchronous to sys_clk
`include "mcuid_defines.svh"
`default_nettype none
// Function
// - destination bit picks accumulator or file
// - nibbles 0111 add, 0010 subtract; C DC Z
// - nibbles 0101/0100/0110 and/or/xor, Z only
// - inc/dec set Z; skip-zero forms skip
// - rotate left/right through carry, C only
// - bit pattern 00bb clears selected bit
// - bit pattern 01bb sets selected bit
// - 10bb/11bb skip on clear/set bit
// - literal add into accumulator, C DC Z
// - literal minus accumulator, C DC Z
// - literal or/and/xor into accumulator, Z
// - load literal; load literal and return
// - program counter changes take two cycles
// - standby and watchdog clear update TO PD
// - port self-modify reads pin levels
// - timer zero write clears assigned prescaler
// - xor accumulator with file updates Z
// - seven-bit address within selected bank
// - four oscillator periods per instruction cycle
module mcuid_core
  import mcuid_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire mcuid_pkg::mcuid_word_t instrWord,
  output mcuid_pkg::mcuid_pc_t progAddr,
  output logic [8:0] fileAddr,
  input wire logic [7:0] fileRdData,
  input wire logic [7:0] pinData,
  output logic [7:0] fileWrData,
  output logic fileWrEn,
  input wire logic prescalerAssigned,
  output logic prescalerClear,
  output logic watchdogClear,
  output logic sleepReq,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData
);
  import mcuid_pkg::*;

  // ==========================================================================
  // reset release
  logic rstSync1_q;
  logic rstSync2_q;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstSync1_q <= 1'b0;
      rstSync2_q <= 1'b0;
    end
    else
    begin
      rstSync1_q <= 1'b1;
      rstSync2_q <= rstSync1_q;
    end
  end
  wire logic rstLocal_n = rstSync2_q;

  // ==========================================================================
  // helpers
  // returns {carry out of bit 7, carry out of bit 3, sum}
  function automatic logic [9:0] addFlags(input logic [7:0] a, input logic [7:0] b, input logic cin);
    logic [4:0] lo;
    logic [8:0] full;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    return {full[8], lo[4], full[7:0]};
  endfunction

  function automatic logic isPortAddr(input logic [6:0] f);
    return (f >= `MCUID_ADDR_PORT_FIRST) && (f <= `MCUID_ADDR_PORT_LAST);
  endfunction

  // ==========================================================================
  // phase sequencer: one instruction cycle every four clocks
  mcuid_phase_t phase_q;
  mcuid_phase_t phase_d;
  always_comb
  begin
    case (phase_q)
      PH_Q1: phase_d = PH_Q2;
      PH_Q2: phase_d = PH_Q3;
      PH_Q3: phase_d = PH_Q4;
      PH_Q4: phase_d = PH_Q1;
      default: phase_d = PH_Q1;
    endcase
  end
  logic runEn_q;
  always_ff @(posedge sys_clk or negedge rstLocal_n)
  begin
    if (!rstLocal_n)
      phase_q <= PH_Q1;
    else if (runEn_q)
      phase_q <= phase_d;
  end
  wire logic execEn = runEn_q && (phase_q == PH_Q4);

  // ==========================================================================
  // fetch latch and operand capture
  mcuid_word_t instr_q;
  logic [7:0] operand_q;
  logic [1:0] bankSel_q;
  logic [1:0] pageSel_q;
  always_ff @(posedge sys_clk or negedge rstLocal_n)
  begin
    if (!rstLocal_n)
    begin
      instr_q <= '0;
      operand_q <= 8'h00;
    end
    else if (runEn_q && phase_q == PH_Q1)
      instr_q <= instrWord;
    else if (runEn_q && phase_q == PH_Q3)
      operand_q <= isPortAddr(instr_q[6:0]) ? pinData : fileRdData;
  end

  // address driven from Q2 so the file answers by Q3
  always_ff @(posedge sys_clk or negedge rstLocal_n)
  begin
    if (!rstLocal_n)
      fileAddr <= 9'h000;
    else if (runEn_q && phase_q == PH_Q2)
      fileAddr <= {bankSel_q, instr_q[6:0]};
  end

  // ==========================================================================
  // decode and execute
  wire logic [1:0] grp = instr_q[13:12];
  wire logic [3:0] nib = instr_q[11:8];
  wire logic dBit = instr_q[7];
  wire logic [2:0] bitPos = instr_q[9:7];
  wire logic [7:0] lit = instr_q[7:0];
  logic [7:0] acc_q;
  logic carry_q;
  logic digitCarry_q;
  logic zero_q;
  logic timeout_q;
  logic powerdown_q;
  logic flush_q;
  mcuid_pc_t pc_q;

  logic [7:0] res;
  logic toAcc;
  logic toFile;
  logic updC;
  logic updDC;
  logic updZ;
  logic newC;
  logic newDC;
  logic skip;
  logic jump;
  logic push;
  logic pop;
  logic standbyOp;
  logic wdtOp;
  logic [9:0] sum;
  logic [7:0] mask;
  always_comb
  begin
    res = 8'h00;
    toAcc = 1'b0;
    toFile = 1'b0;
    updC = 1'b0;
    updDC = 1'b0;
    updZ = 1'b0;
    newC = carry_q;
    newDC = digitCarry_q;
    skip = 1'b0;
    jump = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    standbyOp = 1'b0;
    wdtOp = 1'b0;
    sum = 10'h000;
    mask = 8'h01 << bitPos;
    case (grp)
      2'b00:
      begin
        // result goes to accumulator when d is 0, file when 1
        toAcc = !dBit;
        toFile = dBit;
        updZ = 1'b1;
        case (nib)
          `MCUID_OP_MISC:
          begin
            toAcc = 1'b0;
            updZ = 1'b0;
            res = acc_q;
            if (instr_q[6:0] == `MCUID_WORD_RETURN || instr_q[6:0] == `MCUID_WORD_RETURN_INT)
              pop = !dBit;
            standbyOp = !dBit && instr_q[6:0] == `MCUID_WORD_STANDBY;
            wdtOp = !dBit && instr_q[6:0] == `MCUID_WORD_WATCHDOG_CLEAR_OP;
          end
          `MCUID_OP_CLEAR: res = 8'h00;
          `MCUID_OP_ADD_ACC_TO_FILE, `MCUID_OP_SUB_ACC_FROM_FILE:
          begin
            // subtraction adds the complement, so carry means no borrow
            if (nib == `MCUID_OP_ADD_ACC_TO_FILE)
              sum = addFlags(operand_q, acc_q, 1'b0);
            else
              sum = addFlags(operand_q, ~acc_q, 1'b1);
            res = sum[7:0];
            {newC, newDC} = sum[9:8];
            updC = 1'b1;
            updDC = 1'b1;
          end
          `MCUID_OP_AND_ACC_WITH_FILE: res = acc_q & operand_q;
          `MCUID_OP_OR_ACC_WITH_FILE: res = acc_q | operand_q;
          `MCUID_OP_XOR_ACC_WITH_FILE: res = acc_q ^ operand_q;
          `MCUID_OP_MOVE_FILE: res = operand_q;
          `MCUID_OP_COMPLEMENT_FILE: res = ~operand_q;
          `MCUID_OP_INC_FILE: res = operand_q + 8'h01;
          `MCUID_OP_DEC_FILE: res = operand_q - 8'h01;
          `MCUID_OP_INC_FILE_SKIP_ZERO, `MCUID_OP_DEC_FILE_SKIP_ZERO:
          begin
            res = (nib == `MCUID_OP_INC_FILE_SKIP_ZERO) ? operand_q + 8'h01 : operand_q - 8'h01;
            updZ = 1'b0;
            skip = (res == 8'h00);
          end
          `MCUID_OP_ROTATE_LEFT_CARRY:
          begin
            res = {operand_q[6:0], carry_q};
            newC = operand_q[7];
            updC = 1'b1;
            updZ = 1'b0;
          end
          `MCUID_OP_ROTATE_RIGHT_CARRY:
          begin
            res = {carry_q, operand_q[7:1]};
            newC = operand_q[0];
            updC = 1'b1;
            updZ = 1'b0;
          end
          `MCUID_OP_SWAP_NIBBLES:
          begin
            res = {operand_q[3:0], operand_q[7:4]};
            updZ = 1'b0;
          end
          default: updZ = 1'b0;
        endcase
        // the clear-accumulator form has d = 0 and stores zero in the accumulator
        if (nib == `MCUID_OP_CLEAR)
        begin
          toAcc = !dBit;
          toFile = dBit;
        end
      end
      2'b01:
      begin
        // bit group never touches status
        res = operand_q;
        case (instr_q[11:10])
          2'b00:
          begin
            res = operand_q & ~mask;
            toFile = 1'b1;
          end
          2'b01:
          begin
            res = operand_q | mask;
            toFile = 1'b1;
          end
          2'b10: skip = (operand_q & mask) == 8'h00;
          2'b11: skip = (operand_q & mask) != 8'h00;
          default: skip = 1'b0;
        endcase
      end
      2'b10:
      begin
        jump = 1'b1;
        push = !instr_q[11];
      end
      default:
      begin
        toAcc = 1'b1;
        updZ = 1'b1;
        res = lit;
        if (nib[3:1] == 3'b111 || nib[3:1] == 3'b110)
        begin
          if (nib[1])
            sum = addFlags(lit, acc_q, 1'b0);
          else
            sum = addFlags(lit, ~acc_q, 1'b1);
          res = sum[7:0];
          {newC, newDC} = sum[9:8];
          updC = 1'b1;
          updDC = 1'b1;
        end
        else if (nib == `MCUID_LIT_OR_LITERAL_ACC)
          res = lit | acc_q;
        else if (nib == `MCUID_LIT_AND_LITERAL_ACC)
          res = lit & acc_q;
        else if (nib == `MCUID_LIT_XOR_LITERAL_ACC)
          res = lit ^ acc_q;
        else if (nib[3:2] == 2'b00)
          updZ = 1'b0;
        else if (nib[3:2] == 2'b01)
        begin
          updZ = 1'b0;
          pop = 1'b1;
        end
        else
        begin
          toAcc = 1'b0;
          updZ = 1'b0;
        end
      end
    endcase
  end
  // a flushed cycle executes as a no-operation
  wire logic doExec = execEn && !flush_q;

  // ==========================================================================
  // accumulator and status flags
  always_ff @(posedge sys_clk or negedge rstLocal_n)
  begin
    if (!rstLocal_n)
    begin
      acc_q <= 8'h00;
      carry_q <= 1'b0;
      digitCarry_q <= 1'b0;
      zero_q <= 1'b0;
    end
    else if (doExec)
    begin
      if (toAcc)
        acc_q <= res;
      if (updC)
        carry_q <= newC;
      if (updDC)
        digitCarry_q <= newDC;
      if (updZ)
        zero_q <= (res == 8'h00);
    end
  end

  // power-up shows both bits set; standby clears power-down, watchdog clear sets it
  always_ff @(posedge sys_clk or negedge rstLocal_n)
  begin
    if (!rstLocal_n)
    begin
      timeout_q <= 1'b1;
      powerdown_q <= 1'b1;
    end
    else if (doExec && (standbyOp || wdtOp))
    begin
      timeout_q <= 1'b1;
      powerdown_q <= wdtOp;
    end
  end

  // ==========================================================================
  // file write, side-effect pulses
  always_ff @(posedge sys_clk or negedge rstLocal_n)
  begin
    if (!rstLocal_n)
    begin
      fileWrEn <= 1'b0;
      fileWrData <= 8'h00;
      prescalerClear <= 1'b0;
      watchdogClear <= 1'b0;
      sleepReq <= 1'b0;
    end
    else
    begin
      fileWrEn <= doExec && toFile;
      fileWrData <= res;
      prescalerClear <= doExec && toFile && prescalerAssigned &&
                        instr_q[6:0] == `MCUID_ADDR_TIMER_ZERO_COUNT;
      watchdogClear <= doExec && (wdtOp || standbyOp);
      sleepReq <= doExec && standbyOp;
    end
  end

  // ==========================================================================
  // program counter, stack and the dead cycle after a change of flow
  logic [12:0] stack_q [`MCUID_STACK_DEPTH];
  logic [2:0] sp_q;
  always_ff @(posedge sys_clk or negedge rstLocal_n)
  begin
    if (!rstLocal_n)
    begin
      pc_q <= '0;
      sp_q <= 3'h0;
      flush_q <= 1'b0;
    end
    else if (execEn)
    begin
      // the flushed cycle holds the counter so the target is fetched next
      flush_q <= !flush_q && (jump || pop || skip);
      if (flush_q)
        pc_q <= pc_q;
      else if (jump)
        pc_q <= {pageSel_q, instr_q[10:0]};
      else if (pop)
        pc_q <= stack_q[sp_q - 3'h1];
      else if (skip)
        pc_q <= pc_q + 13'h0002;
      else
        pc_q <= pc_q + 13'h0001;
      // stack wraps silently on overflow, as a circular buffer
      if (!flush_q && push)
        sp_q <= sp_q + 3'h1;
      else if (!flush_q && pop)
        sp_q <= sp_q - 3'h1;
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (doExec && push)
      stack_q[sp_q] <= pc_q + 13'h0001;
  end
  assign progAddr = pc_q;

  // ==========================================================================
  // software register port
  always_ff @(posedge sys_clk or negedge rstLocal_n)
  begin
    if (!rstLocal_n)
    begin
      runEn_q <= 1'b0;
      bankSel_q <= 2'b00;
      pageSel_q <= 2'b00;
    end
    else if (regWrEn && regAddr == `MCUID_REG_CTRL)
    begin
      runEn_q <= regWrData[`MCUID_CTRL_RUN_BIT];
      bankSel_q <= regWrData[2:1];
      pageSel_q <= regWrData[4:3];
    end
  end
  // read data valid only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rstLocal_n)
  begin
    if (!rstLocal_n)
      regRdData <= 8'h00;
    else if (!regRdEn)
      regRdData <= 8'h00;
    else
    begin
      case (regAddr)
        `MCUID_REG_CTRL: regRdData <= {3'h0, pageSel_q, bankSel_q, runEn_q};
        `MCUID_REG_FLAGS: regRdData <= {2'h0, flush_q, timeout_q, powerdown_q, zero_q, digitCarry_q, carry_q};
        `MCUID_REG_ACC: regRdData <= acc_q;
        `MCUID_REG_PC_LOW: regRdData <= pc_q[7:0];
        default: regRdData <= 8'h00;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> mcuid_core_monitor.sv
// port checker for the instruction decoder, bound into the core
// assumes instrWord follows progAddr at once, so $past(instrWord) is the executed word
`include "mcuid_defines.svh"
`default_nettype none
module mcuid_core_monitor
  import mcuid_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire mcuid_pkg::mcuid_word_t instrWord,
  input wire mcuid_pkg::mcuid_pc_t progAddr,
  input wire logic [8:0] fileAddr,
  input wire logic fileWrEn,
  input wire logic prescalerAssigned,
  input wire logic prescalerClear,
  input wire logic watchdogClear,
  input wire logic sleepReq
);
  import mcuid_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // ==========
  // program counter steps
  sequence s_pc_moved;
    $changed(progAddr);
  endsequence
  sequence s_pc_jumped;
    $changed(progAddr) && (progAddr != $past(progAddr) + 13'h1);
  endsequence
  // a jump or taken skip costs the flushed cycle, so the counter rests for two cycles
  property p_flush_hold;
    s_pc_jumped |=> $stable(progAddr)[*7];
  endproperty
  property p_pc_spacing;
    s_pc_moved |=> $stable(progAddr)[*3];
  endproperty
  // ==========
  // file writes
  // d=0 byte ops, bit tests and literal or control words never write a file
  property p_wr_dest;
    fileWrEn |-> !$past(instrWord[13]) && !($past(instrWord[13:11]) == 3'b011)
      && !($past(instrWord[13:12]) == 2'b00 && $past(instrWord[11:9]) != 3'h0 && !$past(instrWord[7]));
  endproperty
  property p_wr_addr;
    fileWrEn |-> fileAddr[6:0] == $past(instrWord[6:0]);
  endproperty
  property p_wr_spacing;
    fileWrEn |=> !fileWrEn[*3];
  endproperty
  // ==========
  // prescaler and standby side effects
  property p_pre_cause;
    prescalerClear |-> fileWrEn && fileAddr[6:0] == `MCUID_ADDR_TIMER_ZERO_COUNT;
  endproperty
  property p_pre_when;
    fileWrEn && fileAddr[6:0] == `MCUID_ADDR_TIMER_ZERO_COUNT && $past(prescalerAssigned) |-> prescalerClear;
  endproperty
  property p_standby;
    sleepReq |-> watchdogClear && $past(instrWord) == 14'h0063;
  endproperty
  property p_wdog_word;
    watchdogClear |-> $past(instrWord) == 14'h0063 || $past(instrWord) == 14'h0064;
  endproperty
  a_flush_hold: assert property (p_flush_hold) else $error("counter moved inside a flushed cycle");
  a_pc_spacing: assert property (p_pc_spacing) else $error("counter moved within four clocks");
  a_wr_dest: assert property (p_wr_dest) else $error("file written by a word that keeps its result");
  a_wr_addr: assert property (p_wr_addr) else $error("file write at wrong address");
  a_wr_spacing: assert property (p_wr_spacing) else $error("two file writes in one cycle");
  a_pre_cause: assert property (p_pre_cause) else $error("prescaler cleared without timer write");
  a_pre_when: assert property (p_pre_when) else $error("timer write left prescaler alone");
  a_standby: assert property (p_standby) else $error("standby pulse without standby word");
  a_wdog_word: assert property (p_wdog_word) else $error("watchdog clear from wrong word");
endmodule
bind mcuid_core mcuid_core_monitor mcuid_core_monitor_inst (
  .sys_clk(sys_clk), .rst_n(rst_n), .instrWord(instrWord), .progAddr(progAddr), .fileAddr(fileAddr),
  .fileWrEn(fileWrEn), .prescalerAssigned(prescalerAssigned), .prescalerClear(prescalerClear),
  .watchdogClear(watchdogClear), .sleepReq(sleepReq)
);
`default_nettype wire

// >>> mcuid_prog_model.sv
// program memory and one bank of register file facing the decoder
// assumes the bench preloads both arrays while the core is stopped
`default_nettype none
module mcuid_prog_model
  import mcuid_pkg::*;
(
  input wire logic sys_clk,
  input wire mcuid_pkg::mcuid_pc_t progAddr,
  output mcuid_pkg::mcuid_word_t instrWord,
  input wire logic [8:0] fileAddr,
  output logic [7:0] fileRdData,
  input wire logic [7:0] fileWrData,
  input wire logic fileWrEn
);
  import mcuid_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  mcuid_word_t progMem [64];
  logic [7:0] fileMem [128];
  // both memories answer at once; only 64 words, upper counter bits are ignored
  assign instrWord = progMem[progAddr[5:0]];
  assign fileRdData = fileMem[fileAddr[6:0]];
  // writes land at the edge that sees the pulse
  always @(posedge sys_clk)
  begin
    if (fileWrEn)
      fileMem[fileAddr[6:0]] <= fileWrData;
  end
endmodule
`default_nettype wire

// >>> mcuid_core_bench.sv
// self-checking bench: loads short programs, runs the core, reads results back
// assumes the core, the memory model and the bound checker are compiled with it
`include "mcuid_defines.svh"
`default_nettype none
`define CHK(got, exp) \
  begin checkCount++; if ((got) !== (exp)) begin miscompares++; \
  $display("Error at %0t ns: got %h expected %h", $time, got, exp); end end
module mcuid_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [7:0] pinData = 8'ha5;
  logic prescalerAssigned = 1'b1;
  logic [13:0] instrWord;
  logic [12:0] progAddr;
  logic [8:0] fileAddr;
  logic [7:0] fileRdData;
  logic [7:0] fileWrData;
  logic fileWrEn;
  logic prescalerClear;
  logic watchdogClear;
  logic sleepReq;
  logic [7:0] regRdData;
  logic [13:0] prog [$];
  int miscompares = 0;
  int checkCount = 0;
  int clearCount;
  int sleepCount;
  int wdogCount;
  always #5 sys_clk = ~sys_clk;
  mcuid_core mcuid_core_inst (.sys_clk(sys_clk), .rst_n(rst_n), .instrWord(instrWord), .progAddr(progAddr),
    .fileAddr(fileAddr), .fileRdData(fileRdData), .pinData(pinData), .fileWrData(fileWrData),
    .fileWrEn(fileWrEn), .prescalerAssigned(prescalerAssigned), .prescalerClear(prescalerClear),
    .watchdogClear(watchdogClear), .sleepReq(sleepReq), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData));
  mcuid_prog_model mcuid_prog_model_inst (.sys_clk(sys_clk), .progAddr(progAddr), .instrWord(instrWord),
    .fileAddr(fileAddr), .fileRdData(fileRdData), .fileWrData(fileWrData), .fileWrEn(fileWrEn));
  // pulse tallies, cleared by every reset
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      clearCount <= 0;
      sleepCount <= 0;
      wdogCount <= 0;
    end
    else
    begin
      if (prescalerClear === 1'b1) clearCount <= clearCount + 1;
      if (sleepReq === 1'b1) sleepCount <= sleepCount + 1;
      if (watchdogClear === 1'b1) wdogCount <= wdogCount + 1;
    end
  end
  // ==========
  // register port
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe; the mask hides the flush bit
  task automatic reg_read(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] mask = 8'hff);
    @(posedge sys_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    #1;
    `CHK(regRdData & mask, exp)
  endtask
  // ==========
  // program runs
  task automatic reset_load();
    @(posedge sys_clk);
    rst_n <= 1'b0;
    for (int i = 0; i < 128; i++) mcuid_prog_model_inst.fileMem[i] = 8'h00;
    for (int i = 0; i < 64; i++) mcuid_prog_model_inst.progMem[i] = (i < prog.size()) ? prog[i] : 14'h0000;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic run_for(input int cycles);
    reg_write(`MCUID_REG_CTRL, 8'h01);
    repeat (cycles * `MCUID_OSC_PER_CYCLE) @(posedge sys_clk);
    reg_write(`MCUID_REG_CTRL, 8'h00);
  endtask
  task automatic print_verdict();
    if (miscompares == 0 && checkCount > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // a hung core must still end the run
  initial
  begin
    #50000;
    miscompares++;
    print_verdict();
  end
  initial
  begin
    // arithmetic, logic and destination select
    prog = '{14'h300f, 14'h3e01, 14'h00a0, 14'h07a0, 14'h0220, 14'h0620, 14'h3a30, 14'h3c05,
      14'h3810, 14'h390a, 14'h280a};
    reset_load();
    reg_read(`MCUID_REG_FLAGS, 8'h18);
    reg_write(`MCUID_REG_ACC, 8'h5a);
    reg_read(`MCUID_REG_ACC, 8'h00);
    reg_write(8'h10, 8'hff);
    reg_read(8'h10, 8'h00);
    reg_write(`MCUID_REG_CTRL, 8'h1e);
    reg_read(`MCUID_REG_CTRL, 8'h1e);
    run_for(16);
    reg_read(`MCUID_REG_ACC, 8'h00);
    reg_read(`MCUID_REG_FLAGS, 8'h1f, 8'h1f);
    reg_read(`MCUID_REG_PC_LOW, 8'h0a);
    `CHK(mcuid_prog_model_inst.fileMem[8'h20], 8'h20)
    // bit set, clear, tests, rotates and skip-zero
    prog = '{14'h3081, 14'h00a1, 14'h15a1, 14'h1021, 14'h1da1, 14'h0aa3, 14'h0d21, 14'h1ba1,
      14'h0ca1, 14'h0ba2, 14'h0aa3, 14'h280b};
    reset_load();
    mcuid_prog_model_inst.fileMem[8'h22] = 8'h01;
    run_for(20);
    reg_read(`MCUID_REG_ACC, 8'h10);
    reg_read(`MCUID_REG_FLAGS, 8'h18, 8'h1f);
    reg_read(`MCUID_REG_PC_LOW, 8'h0b);
    `CHK(mcuid_prog_model_inst.fileMem[8'h21], 8'hc4)
    `CHK(mcuid_prog_model_inst.fileMem[8'h22], 8'h00)
    `CHK(mcuid_prog_model_inst.fileMem[8'h23], 8'h00)
    // call and return, port read from pins, timer write, watchdog and standby
    prog = '{14'h2006, 14'h0a85, 14'h0181, 14'h0064, 14'h0063, 14'h2805, 14'h3442};
    reset_load();
    mcuid_prog_model_inst.fileMem[8'h01] = 8'h77;
    run_for(16);
    reg_read(`MCUID_REG_ACC, 8'h42);
    reg_read(`MCUID_REG_FLAGS, 8'h14, 8'h1f);
    reg_read(`MCUID_REG_PC_LOW, 8'h05);
    `CHK(mcuid_prog_model_inst.fileMem[8'h05], 8'ha6)
    `CHK(mcuid_prog_model_inst.fileMem[8'h01], 8'h00)
    `CHK(clearCount, 1)
    `CHK(sleepCount, 1)
    `CHK(wdogCount, 2)
    print_verdict();
  end
endmodule
`default_nettype wire
